/* File: verilog/cptc_pkg.sv */
// Shared constants and types for the codec power and transmit control block
package cptc_pkg;

    // ****************************************************************
    // Clock and timing
    // ****************************************************************
    localparam int CLOCK_PERIOD_NS = 10;
    // Master clock counts as lost after this long without any transition
    localparam int MCLK_LOSS_NS = 5000;
    localparam int MCLK_LOSS_CYCLES = MCLK_LOSS_NS / CLOCK_PERIOD_NS;
    localparam int LOSS_CNT_W = 10;

    // ****************************************************************
    // Configuration registers
    // ****************************************************************
    localparam int CFG_COUNT = 6;
    localparam int CFG_ADDR_W = 4;
    localparam logic [CFG_ADDR_W-1:0] CFG_ZERO_IDX = 4'h0;
    localparam logic [CFG_ADDR_W-1:0] CFG_ONE_IDX = 4'h1;
    localparam logic [CFG_ADDR_W-1:0] CFG_FOUR_IDX = 4'h4;
    localparam logic [CFG_ADDR_W-1:0] CFG_FIVE_IDX = 4'h5;
    localparam logic [CFG_COUNT*8-1:0] CFG_RESET = 48'h0000_0000_0000;

    // Field positions
    localparam int CR0_RATE_LSB = 4;
    localparam int CR0_CODING_BIT = 3;
    localparam int CR0_FORMAT_BIT = 2;
    localparam int CR1_MODE_LSB = 6;
    localparam int CR1_DRIVE_BIT = 3;
    localparam int CR1_ENABLE_BIT = 2;
    localparam int CR1_SLOT_BIT = 1;
    localparam int CR4_INPUT_LSB = 6;
    localparam int CR5_GAIN_LSB = 4;

    // Instruction byte layout
    localparam int INSTR_POWER_BIT = 7;
    localparam int INSTR_ADDR_LSB = 3;
    localparam int INSTR_TWO_BYTE_BIT = 1;

    // ****************************************************************
    // Encodings
    // ****************************************************************
    localparam logic [1:0] FMODE_NORMAL = 2'h0;
    localparam logic [1:0] FMODE_DELAYED = 2'h1;
    localparam logic [1:0] FMODE_REVERSE = 2'h2;
    localparam logic [1:0] INSEL_ONE = 2'h0;
    localparam logic [1:0] INSEL_TWO = 2'h1;
    localparam logic [1:0] INSEL_THREE = 2'h2;
    localparam logic [1:0] INSEL_MUTE = 2'h3;

    // Slot geometry, in master clock bits from frame start, and frame syncs before the output drives
    localparam logic [7:0] SLOT_B2_OFS_F1 = 8'h08;
    localparam logic [7:0] SLOT_B2_OFS_F2 = 8'h0a;
    localparam logic [7:0] SLOT_LEN_COMPANDED = 8'h08;
    localparam logic [7:0] SLOT_LEN_LINEAR = 8'h10;
    localparam logic [1:0] FRAMES_BEFORE_DRIVE = 2'h2;

    typedef enum logic {CTL_CMD, CTL_DATA} cptc_ctl_e;

endpackage

/* File: verilog/cptc_sync.sv */
// Two flip-flop synchroniser for asynchronous pin inputs
module cptc_sync #(
    parameter int W = 1
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta_q;

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            meta_q <= '0;
            q <= '0;
        end
        else
        begin
            meta_q <= d;
            q <= meta_q;
        end
    end

endmodule

/* File: verilog/cptc_top.sv */
// Codec power sequencing, control port decode and transmit slot shift-out
// How it works
// - Three frame sync formats supported
// - Master clock rate told via field
// - Master clock sequences and shifts data
// - Output pin drives inverse of drive bit
// - Reset: powered down, defaults, codec off
// - Settings writable while powered down
// - Power bit 0 up, 1 down
// - Registers writable in both power states
// - Transmit output floats until second frame
// - Power down keeps register contents
// - Lost master clock forces power down
// - Bits 7:6 select input or mute
// - Mute grounds transmit, disables sidetone
// - Four-bit second stage gain field
// - Coding bit: linear or companded
// - Encode starts at transmit slot start
// - Shift edge depends on frame format
// - Output floats outside transmit slot
// - Control bits shift on rising clock
module cptc_top (
    input wire logic clock,
    input wire logic resetn,
    input wire logic mclk_pin,
    input wire logic frame_sync_in,
    input wire logic control_shift_clock,
    input wire logic control_select_n,
    input wire logic control_serial_in,
    input wire logic [13:0] tx_sample,
    output logic transmit_pcm_out,
    output logic transmit_pcm_out_en_n,
    output logic encode_start,
    output logic general_purpose_out_pin,
    output logic codec_enable,
    output logic mclk_lost,
    output logic [1:0] mclk_rate_sel,
    output logic coding_select_bit,
    output logic [1:0] frame_mode,
    output logic transmit_input_one,
    output logic transmit_input_two,
    output logic transmit_input_three,
    output logic transmit_mute,
    output logic sidetone_enable,
    output logic [3:0] tx_gain_code
);

    // ****************************************************************
    // Pin synchronisers and edge detection
    // ****************************************************************
    logic [4:0] pins_s;
    logic mclk_s, fs_s, control_shift_clock_s, csn_s, ci_s;
    logic mclk_prev_q, control_shift_clock_prev_q;
    logic mclk_rise, mclk_fall, control_shift_clock_rise;

    cptc_sync #(.W(5)) u_sync (
        .clock(clock),
        .resetn(resetn),
        .d({mclk_pin, frame_sync_in, control_shift_clock, control_select_n, control_serial_in}),
        .q(pins_s)
    );

    assign {mclk_s, fs_s, control_shift_clock_s, csn_s, ci_s} = pins_s;

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            mclk_prev_q <= 1'b0;
            control_shift_clock_prev_q <= 1'b0;
        end
        else
        begin
            mclk_prev_q <= mclk_s;
            control_shift_clock_prev_q <= control_shift_clock_s;
        end
    end

    // Master clock is oversampled, so data moves on its sampled edges
    assign mclk_rise = mclk_s & ~mclk_prev_q;
    assign mclk_fall = ~mclk_s & mclk_prev_q;
    // Control clock is asynchronous; it must stay well below a quarter of clock
    assign control_shift_clock_rise = control_shift_clock_s & ~control_shift_clock_prev_q & ~csn_s;

    // ****************************************************************
    // Control port: byte shift and instruction decode
    // ****************************************************************
    cptc_pkg::cptc_ctl_e ctl_q, ctl_d;
    logic [7:0] shift_q, shift_d;
    logic [7:0] cmd_q, cmd_d;
    logic [2:0] bits_q, bits_d;
    logic [cptc_pkg::CFG_COUNT*8-1:0] cfg_q, cfg_d;
    logic instr_done;
    logic instr_power;
    logic [7:0] byte_in;

    always_comb
    begin
        ctl_d = ctl_q;
        shift_d = shift_q;
        cmd_d = cmd_q;
        bits_d = bits_q;
        cfg_d = cfg_q;
        instr_done = 1'b0;
        instr_power = 1'b0;
        byte_in = {shift_q[6:0], ci_s};
        // A select pulse that ends mid-byte drops the partial byte
        if (csn_s)
        begin
            bits_d = 3'h0;
        end
        else if (control_shift_clock_rise)
        begin
            shift_d = byte_in;
            bits_d = bits_q + 3'h1;
            if (bits_q == 3'h7)
            begin
                unique case (ctl_q)
                    cptc_pkg::CTL_CMD:
                    begin
                        if (byte_in[cptc_pkg::INSTR_TWO_BYTE_BIT])
                        begin
                            cmd_d = byte_in;
                            ctl_d = cptc_pkg::CTL_DATA;
                        end
                        else
                        begin
                            // Single byte power instruction
                            instr_done = 1'b1;
                            instr_power = byte_in[cptc_pkg::INSTR_POWER_BIT];
                        end
                    end
                    cptc_pkg::CTL_DATA:
                    begin
                        // Writes land regardless of power state
                        for (int i = 0; i < cptc_pkg::CFG_COUNT; i++)
                        begin
                            if (cmd_q[cptc_pkg::INSTR_ADDR_LSB +: cptc_pkg::CFG_ADDR_W] == i[3:0])
                            begin
                                cfg_d[i*8 +: 8] = byte_in;
                            end
                        end
                        instr_done = 1'b1;
                        instr_power = cmd_q[cptc_pkg::INSTR_POWER_BIT];
                        ctl_d = cptc_pkg::CTL_CMD;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            ctl_q <= cptc_pkg::CTL_CMD;
            shift_q <= 8'h00;
            cmd_q <= 8'h00;
            bits_q <= 3'h0;
            cfg_q <= cptc_pkg::CFG_RESET;
        end
        else
        begin
            ctl_q <= ctl_d;
            shift_q <= shift_d;
            cmd_q <= cmd_d;
            bits_q <= bits_d;
            cfg_q <= cfg_d;
        end
    end

    // ****************************************************************
    // Power state and master clock loss
    // ****************************************************************
    logic power_down_q, power_down_d;
    logic lost_q, lost_d;
    logic [cptc_pkg::LOSS_CNT_W-1:0] loss_cnt_q, loss_cnt_d;
    logic [1:0] frames_q, frames_d;
    logic fs_rise;

    always_comb
    begin
        loss_cnt_d = loss_cnt_q;
        lost_d = lost_q;
        power_down_d = power_down_q;
        frames_d = frames_q;
        // Counted on clock, so a stopped master clock is still seen
        if (mclk_rise | mclk_fall)
        begin
            loss_cnt_d = '0;
            lost_d = 1'b0;
        end
        else if (loss_cnt_q == cptc_pkg::MCLK_LOSS_CYCLES[cptc_pkg::LOSS_CNT_W-1:0] - 1'b1)
        begin
            lost_d = 1'b1;
        end
        else
        begin
            loss_cnt_d = loss_cnt_q + 1'b1;
        end
        if (instr_done)
        begin
            power_down_d = instr_power;
        end
        // Forced down while the clock is lost, and stays down after it returns until a power up instruction
        if (lost_d)
        begin
            power_down_d = 1'b1;
        end
        if (power_down_d)
        begin
            frames_d = 2'h0;
        end
        else if (fs_rise && frames_q != cptc_pkg::FRAMES_BEFORE_DRIVE)
        begin
            frames_d = frames_q + 2'h1;
        end
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            loss_cnt_q <= '0;
            lost_q <= 1'b0;
            power_down_q <= 1'b1;
            frames_q <= 2'h0;
        end
        else
        begin
            loss_cnt_q <= loss_cnt_d;
            lost_q <= lost_d;
            power_down_q <= power_down_d;
            frames_q <= frames_d;
        end
    end

    // ****************************************************************
    // Transmit framing and shift-out
    // ****************************************************************
    logic [7:0] cr0, cr1;
    logic [1:0] fmode;
    logic cm_bit;
    logic fs_prev_q, fs_prev_d;
    logic pend_q, pend_d;
    logic valid_q, valid_d;
    logic [7:0] bit_q, bit_d;
    logic [15:0] sreg_q, sreg_d;
    logic shift_evt, start_now;
    logic [7:0] slot_ofs, slot_len;
    logic in_slot, drive_ok;
    logic pcm_d, pcm_en_n_d, enc_d;

    assign cr0 = cfg_q[cptc_pkg::CFG_ZERO_IDX*8 +: 8];
    assign cr1 = cfg_q[cptc_pkg::CFG_ONE_IDX*8 +: 8];
    assign fmode = cr1[cptc_pkg::CR1_MODE_LSB +: 2];
    assign cm_bit = cr0[cptc_pkg::CR0_CODING_BIT];
    // Frame sync is sampled on master clock rising edges
    assign fs_rise = mclk_rise & fs_s & ~fs_prev_q;
    assign shift_evt = (fmode == cptc_pkg::FMODE_REVERSE) ? mclk_fall : mclk_rise;
    assign start_now = fs_rise & (fmode != cptc_pkg::FMODE_DELAYED) & (fmode != cptc_pkg::FMODE_REVERSE);

    always_comb
    begin
        fs_prev_d = mclk_rise ? fs_s : fs_prev_q;
        pend_d = pend_q;
        valid_d = valid_q;
        bit_d = bit_q;
        sreg_d = sreg_q;
        enc_d = 1'b0;
        // Linear code only uses the first slot
        slot_len = cm_bit ? cptc_pkg::SLOT_LEN_COMPANDED : cptc_pkg::SLOT_LEN_LINEAR;
        if (cm_bit & cr1[cptc_pkg::CR1_SLOT_BIT])
        begin
            slot_ofs = cr0[cptc_pkg::CR0_FORMAT_BIT] ? cptc_pkg::SLOT_B2_OFS_F2 : cptc_pkg::SLOT_B2_OFS_F1;
        end
        else
        begin
            slot_ofs = 8'h00;
        end
        if (shift_evt)
        begin
            if (start_now | pend_q)
            begin
                bit_d = 8'h00;
                valid_d = 1'b1;
                pend_d = 1'b0;
            end
            else if (bit_q != 8'hff)
            begin
                bit_d = bit_q + 8'h01;
            end
            if (valid_d && bit_d == slot_ofs)
            begin
                enc_d = 1'b1;
                sreg_d = cm_bit ? {tx_sample[7:0], 8'h00} : {tx_sample, 2'b00};
            end
            else
            begin
                sreg_d = {sreg_q[14:0], 1'b0};
            end
        end
        // Delayed and reverse frames begin on the next shift edge
        if (fs_rise & ~start_now)
        begin
            pend_d = 1'b1;
        end
        if (power_down_q)
        begin
            valid_d = 1'b0;
        end
        in_slot = valid_d && bit_d >= slot_ofs && bit_d < slot_ofs + slot_len;
        // Next frame count, so the frame opened by the second sync is already driven
        drive_ok = ~power_down_q & ~lost_d & cr1[cptc_pkg::CR1_ENABLE_BIT] &
            (frames_d == cptc_pkg::FRAMES_BEFORE_DRIVE);
        // Drive only from a slot's first bit, so a config write never opens a slot halfway
        pcm_en_n_d = ~(in_slot & drive_ok & (enc_d | ~transmit_pcm_out_en_n));
        pcm_d = ~pcm_en_n_d & sreg_d[15];
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            fs_prev_q <= 1'b0;
            pend_q <= 1'b0;
            valid_q <= 1'b0;
            bit_q <= 8'hff;
            sreg_q <= 16'h0000;
            transmit_pcm_out <= 1'b0;
            transmit_pcm_out_en_n <= 1'b1;
            encode_start <= 1'b0;
        end
        else
        begin
            fs_prev_q <= fs_prev_d;
            pend_q <= pend_d;
            valid_q <= valid_d;
            bit_q <= bit_d;
            sreg_q <= sreg_d;
            transmit_pcm_out <= pcm_d;
            transmit_pcm_out_en_n <= pcm_en_n_d;
            encode_start <= enc_d & ~power_down_q;
        end
    end

    // ****************************************************************
    // Registered configuration outputs
    // ****************************************************************
    logic [1:0] insel_d;

    always_comb
    begin
        insel_d = cfg_d[cptc_pkg::CFG_FOUR_IDX*8 + cptc_pkg::CR4_INPUT_LSB +: 2];
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            general_purpose_out_pin <= 1'b1;
            codec_enable <= 1'b0;
            mclk_lost <= 1'b0;
            mclk_rate_sel <= 2'h0;
            coding_select_bit <= 1'b0;
            frame_mode <= 2'h0;
            transmit_input_one <= 1'b0;
            transmit_input_two <= 1'b0;
            transmit_input_three <= 1'b0;
            transmit_mute <= 1'b0;
            sidetone_enable <= 1'b0;
            tx_gain_code <= 4'h0;
        end
        else
        begin
            general_purpose_out_pin <= ~cfg_d[cptc_pkg::CFG_ONE_IDX*8 + cptc_pkg::CR1_DRIVE_BIT];
            codec_enable <= ~power_down_d;
            mclk_lost <= lost_d;
            mclk_rate_sel <= cfg_d[cptc_pkg::CFG_ZERO_IDX*8 + cptc_pkg::CR0_RATE_LSB +: 2];
            coding_select_bit <= cfg_d[cptc_pkg::CFG_ZERO_IDX*8 + cptc_pkg::CR0_CODING_BIT];
            frame_mode <= cfg_d[cptc_pkg::CFG_ONE_IDX*8 + cptc_pkg::CR1_MODE_LSB +: 2];
            transmit_input_one <= ~power_down_d & (insel_d == cptc_pkg::INSEL_ONE);
            transmit_input_two <= ~power_down_d & (insel_d == cptc_pkg::INSEL_TWO);
            transmit_input_three <= ~power_down_d & (insel_d == cptc_pkg::INSEL_THREE);
            transmit_mute <= (insel_d == cptc_pkg::INSEL_MUTE);
            sidetone_enable <= ~power_down_d & (insel_d != cptc_pkg::INSEL_MUTE);
            tx_gain_code <= cfg_d[cptc_pkg::CFG_FIVE_IDX*8 + cptc_pkg::CR5_GAIN_LSB +: 4];
        end
    end

endmodule

/* File: tb/cptc_monitor.sv */
// Port-level checker for the codec power and transmit control block
module cptc_monitor (
    input wire logic clock,
    input wire logic resetn,
    input wire logic transmit_pcm_out,
    input wire logic transmit_pcm_out_en_n,
    input wire logic encode_start,
    input wire logic codec_enable,
    input wire logic mclk_lost,
    input wire logic transmit_input_one,
    input wire logic transmit_input_two,
    input wire logic transmit_input_three,
    input wire logic transmit_mute,
    input wire logic sidetone_enable
);
    timeunit 1ns;
    timeprecision 1ns;
    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!resetn);

    chk_float_down: assert property (!codec_enable [*2] |-> transmit_pcm_out_en_n)
        else $error("transmit output driven while powered down");
    chk_lost_down: assert property (mclk_lost |=> !codec_enable)
        else $error("powered up with master clock lost");
    chk_lost_float: assert property (mclk_lost [*2] |-> transmit_pcm_out_en_n)
        else $error("transmit output driven with master clock lost");
    chk_mute_sidetone: assert property (transmit_mute |-> !sidetone_enable)
        else $error("sidetone on while muted");
    chk_sidetone_power: assert property (sidetone_enable |-> codec_enable)
        else $error("sidetone on while powered down");
    chk_input_onehot: assert property ($onehot0({transmit_input_one, transmit_input_two,
        transmit_input_three, transmit_mute}))
        else $error("more than one transmit input selected");
    chk_start_drive: assert property ($fell(transmit_pcm_out_en_n) |-> encode_start)
        else $error("slot began without encode start");
    chk_start_pulse: assert property (encode_start |=> !encode_start)
        else $error("encode start longer than one cycle");
    chk_idle_low: assert property (transmit_pcm_out_en_n |-> !transmit_pcm_out)
        else $error("transmit data not low outside slot");

    cov_slot: cover property ($fell(transmit_pcm_out_en_n));
    cov_lost: cover property ($rose(mclk_lost));
    cov_mute: cover property ($rose(transmit_mute));
    cov_power_up: cover property ($rose(codec_enable));
endmodule

bind cptc_top cptc_monitor cptc_monitor_i (.clock(clock), .resetn(resetn),
    .transmit_pcm_out(transmit_pcm_out), .transmit_pcm_out_en_n(transmit_pcm_out_en_n),
    .encode_start(encode_start), .codec_enable(codec_enable), .mclk_lost(mclk_lost),
    .transmit_input_one(transmit_input_one), .transmit_input_two(transmit_input_two),
    .transmit_input_three(transmit_input_three), .transmit_mute(transmit_mute),
    .sidetone_enable(sidetone_enable));

/* File: tb/cptc_partner.sv */
// Model of the PCM port master and the control microcontroller
module cptc_partner #(
    parameter int FRAME_BITS = 32
) (
    input wire logic clock,
    input wire logic mclk_run,
    output logic mclk_pin,
    output logic frame_sync_in,
    output logic control_shift_clock,
    output logic control_select_n,
    output logic control_serial_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] div = 4'h0;
    int bit_n = 0;

    initial
    begin
        mclk_pin = 1'b0;
        frame_sync_in = 1'b0;
        control_shift_clock = 1'b0;
        control_select_n = 1'b1;
        control_serial_in = 1'b0;
    end

    // ****************************************************************
    // Master clock and frame sync
    // ****************************************************************
    // Frames are shortened to FRAME_BITS so a run spans many frames; sync stops with the clock
    always @(posedge clock)
    begin
        div <= (div == 4'h4) ? 4'h0 : div + 4'h1;
        if (div == 4'h4 && mclk_run)
        begin
            mclk_pin <= ~mclk_pin;
            if (mclk_pin)
            begin
                bit_n <= (bit_n == FRAME_BITS - 1) ? 0 : bit_n + 1;
                frame_sync_in <= (bit_n == FRAME_BITS - 1);
            end
        end
    end

    // ****************************************************************
    // Control port
    // ****************************************************************
    task automatic shift_byte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--)
        begin
            control_serial_in <= b[i];
            repeat (10) @(posedge clock);
            control_shift_clock <= 1'b1;
            repeat (10) @(posedge clock);
            control_shift_clock <= 1'b0;
        end
    endtask

    // Data byte goes out in the same select pulse only when bit 1 of the command asks for it
    task automatic send(input logic [7:0] cmd, input logic [7:0] data);
        control_select_n <= 1'b0;
        repeat (10) @(posedge clock);
        shift_byte(cmd);
        if (cmd[1])
            shift_byte(data);
        repeat (10) @(posedge clock);
        control_select_n <= 1'b1;
        control_serial_in <= ~control_serial_in;
        repeat (20) @(posedge clock);
    endtask
endmodule

/* File: tb/tb_top.sv */
// Self-checking testbench for the codec power and transmit control block
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic mclk_run = 1'b0;
    logic [13:0] tx_sample = 14'h2a5c;
    logic mclk_pin, frame_sync_in, control_shift_clock, control_select_n, control_serial_in;
    logic transmit_pcm_out, transmit_pcm_out_en_n, encode_start, general_purpose_out_pin;
    logic codec_enable, mclk_lost, coding_select_bit, sidetone_enable;
    logic transmit_input_one, transmit_input_two, transmit_input_three, transmit_mute;
    logic [1:0] mclk_rate_sel, frame_mode;
    logic [3:0] tx_gain_code;
    logic [15:0] word;
    int n_fail = 0;
    int comparisons = 0;
    int fs_n, lat, lat0;
    // Delayed, reverse, companded B1, B2 format 1, B2 format 2
    logic [7:0] t_cr0 [5] = '{8'h20, 8'h20, 8'h28, 8'h28, 8'h2c};
    logic [7:0] t_cr1 [5] = '{8'h44, 8'h84, 8'h04, 8'h06, 8'h06};
    int t_add [5] = '{10, 5, 0, 80, 100};

    always #5 clock = ~clock;

    cptc_partner cptc_partner_i (.clock(clock), .mclk_run(mclk_run), .mclk_pin(mclk_pin),
        .frame_sync_in(frame_sync_in), .control_shift_clock(control_shift_clock),
        .control_select_n(control_select_n), .control_serial_in(control_serial_in));
    cptc_top cptc_top_i (.clock(clock), .resetn(resetn), .mclk_pin(mclk_pin), .frame_sync_in(frame_sync_in),
        .control_shift_clock(control_shift_clock), .control_select_n(control_select_n),
        .control_serial_in(control_serial_in), .tx_sample(tx_sample), .transmit_pcm_out(transmit_pcm_out),
        .transmit_pcm_out_en_n(transmit_pcm_out_en_n), .encode_start(encode_start),
        .general_purpose_out_pin(general_purpose_out_pin), .codec_enable(codec_enable), .mclk_lost(mclk_lost),
        .mclk_rate_sel(mclk_rate_sel), .coding_select_bit(coding_select_bit), .frame_mode(frame_mode),
        .transmit_input_one(transmit_input_one), .transmit_input_two(transmit_input_two),
        .transmit_input_three(transmit_input_three), .transmit_mute(transmit_mute),
        .sidetone_enable(sidetone_enable), .tx_gain_code(tx_gain_code));

    // ****************************************************************
    // Helpers
    // ****************************************************************
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Counts frame sync rises and cycles from the latest one until the output starts driving
    task automatic wait_drive(output int fs_seen, output int cyc);
        int t;
        logic fs_q;
        fs_seen = 0;
        cyc = 0;
        fs_q = frame_sync_in;
        for (t = 0; t < 3000 && !(fs_seen > 0 && transmit_pcm_out_en_n === 1'b0); t++)
        begin
            @(posedge clock);
            #1;
            cyc = (frame_sync_in && !fs_q) ? 0 : cyc + 1;
            fs_seen += (frame_sync_in && !fs_q);
            fs_q = frame_sync_in;
        end
        if (t == 3000)
        begin
            n_fail++;
            $display("[FAIL] slot start expected drive seen none");
            conclude();
        end
    endtask

    // Samples mid-bit, one master clock period per bit, then looks half a period past the slot
    task automatic read_slot(input int nbits, output logic [15:0] w);
        w = 16'h0000;
        repeat (5) @(posedge clock);
        for (int i = 0; i < nbits; i++)
        begin
            #1;
            w = {w[14:0], transmit_pcm_out};
            repeat (10) @(posedge clock);
        end
        #1;
        check("idle after slot", 1'b1, transmit_pcm_out_en_n);
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial
    begin
        repeat (4) @(posedge clock);
        resetn <= 1'b1;
        mclk_run <= 1'b1;
        repeat (2) @(posedge clock);
        #1;
        check("codec_enable", 1'b0, codec_enable);
        check("output pin", 1'b1, general_purpose_out_pin);
        check("drive enable", 1'b1, transmit_pcm_out_en_n);
        check("gain", 4'h0, tx_gain_code);
        cptc_partner_i.send(8'h82, 8'h20);
        cptc_partner_i.send(8'h8a, 8'h0c);
        check("output pin", 1'b0, general_purpose_out_pin);
        cptc_partner_i.send(8'haa, 8'hf0);
        check("rate", 2'h2, mclk_rate_sel);
        check("coding", 1'b0, coding_select_bit);
        check("gain", 4'hf, tx_gain_code);
        check("codec_enable", 1'b0, codec_enable);
        cptc_partner_i.send(8'h8a, 8'h04);
        check("output pin", 1'b1, general_purpose_out_pin);
        cptc_partner_i.send(8'h00, 8'h00);
        check("codec_enable", 1'b1, codec_enable);
        wait_drive(fs_n, lat0);
        check("frames before drive", 2, fs_n);
        read_slot(16, word);
        check("linear word", {tx_sample, 2'b00}, word);
        for (int i = 0; i < 5; i++)
        begin
            cptc_partner_i.send(8'h02, t_cr0[i]);
            cptc_partner_i.send(8'h0a, t_cr1[i]);
            wait_drive(fs_n, lat);
            check("slot start", lat0 + t_add[i], lat);
            read_slot(t_cr0[i][3] ? 8 : 16, word);
            check("slot word", t_cr0[i][3] ? {8'h00, tx_sample[7:0]} : {tx_sample, 2'b00}, word);
        end
        for (int s = 0; s < 4; s++)
        begin
            cptc_partner_i.send(8'h22, {s[1:0], 6'h00});
            check("input select", 4'h8 >> s, {transmit_input_one, transmit_input_two,
                transmit_input_three, transmit_mute});
            check("sidetone", s != 3, sidetone_enable);
        end
        cptc_partner_i.send(8'h2a, 8'h90);
        check("gain", 4'h9, tx_gain_code);
        cptc_partner_i.send(8'h80, 8'h00);
        check("codec_enable", 1'b0, codec_enable);
        check("gain kept", 4'h9, tx_gain_code);
        repeat (700) @(posedge clock);
        cptc_partner_i.send(8'h00, 8'h00);
        check("codec_enable", 1'b1, codec_enable);
        mclk_run <= 1'b0;
        repeat (600) @(posedge clock);
        #1;
        check("clock lost", 1'b1, mclk_lost);
        check("codec_enable", 1'b0, codec_enable);
        check("drive enable", 1'b1, transmit_pcm_out_en_n);
        mclk_run <= 1'b1;
        repeat (30) @(posedge clock);
        #1;
        check("clock lost", 1'b0, mclk_lost);
        check("codec_enable", 1'b0, codec_enable);
        resetn <= 1'b0;
        repeat (4) @(posedge clock);
        resetn <= 1'b1;
        repeat (2) @(posedge clock);
        #1;
        check("gain", 4'h0, tx_gain_code);
        check("output pin", 1'b1, general_purpose_out_pin);
        conclude();
    end
endmodule
